/* File: core/iec_enable_ctrl.sv */
// interrupt enable control: enable banks, pending, target state, arbitration
// How it works
// (R1) bit m of bank register n stands for interrupt 32n+m
// (R2) each bank register is 32 bits, one bit per interrupt
// (R3) writing 1 to a set-enable bit enables; 0 does nothing
// (R4) writing 1 to a clear-enable bit disables; 0 does nothing
// (R5) both banks read back the current enable state
// (R6) pending and enabled interrupts compete by priority for activation
// (R7) a disabled interrupt's asserted line still sets pending
// (R8) a disabled interrupt is never activated
// (R9) set-enable bits barred by target state read zero, ignore writes
// (R10) clear-enable bits of secure targets are hidden from non-secure access
// (R11) one shared enable copy serves both security states
// (R12) target-state register reads zero, ignores writes from non-secure
// (R13) lower priority value is more urgent; zero most urgent
// (R14) enable change reaches arbitration the cycle after the write
//
// Chosen here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module iec_enable_ctrl #(
   parameter int NUM_IRQ = 64,
   parameter int IDX_W   = 6
) (
   // clock, reset, enable
   input  wire logic                 aclk,
   input  wire logic                 aresetn,
   input  wire logic                 ce,
   // interrupt request lines, asynchronous
   input  wire logic [NUM_IRQ-1:0]   irq_lines,
   // activation handshake with the core
   output logic                      act_valid,
   output logic [IDX_W-1:0]          act_number,
   input  wire logic                 act_ready,
   // axi4-lite register bus
   input  wire logic [11:0]          s_awaddr,
   input  wire logic [2:0]           s_awprot,
   input  wire logic                 s_awvalid,
   output logic                      s_awready,
   input  wire logic [31:0]          s_wdata,
   input  wire logic [3:0]           s_wstrb,
   input  wire logic                 s_wvalid,
   output logic                      s_wready,
   output logic [1:0]                s_bresp,
   output logic                      s_bvalid,
   input  wire logic                 s_bready,
   input  wire logic [11:0]          s_araddr,
   input  wire logic [2:0]           s_arprot,
   input  wire logic                 s_arvalid,
   output logic                      s_arready,
   output logic [31:0]               s_rdata,
   output logic [1:0]                s_rresp,
   output logic                      s_rvalid,
   input  wire logic                 s_rready,
   // state view
   output logic [NUM_IRQ-1:0]        enabled
);
   localparam int NW = NUM_IRQ / iec_pkg::BANK_BITS;
   localparam int PW = iec_pkg::PRIO_W;
   localparam int BB = iec_pkg::BANK_BITS;
   localparam int LW = iec_pkg::LANE_W;
   localparam int LN = iec_pkg::LANES;

   // one copy for both security states (R11)
   logic [NUM_IRQ-1:0]    en_q;
   logic [NUM_IRQ-1:0]    en_d;
   logic [NUM_IRQ-1:0]    pend_q;
   logic [NUM_IRQ-1:0]    pend_d;
   logic [NUM_IRQ-1:0]    tgt_q;
   logic [NUM_IRQ-1:0]    tgt_d;
   logic [NUM_IRQ*PW-1:0] pri_q;
   logic [NUM_IRQ*PW-1:0] pri_d;
   logic                  secext_q;
   logic                  secext_d;
   // line synchroniser and edge history
   logic [NUM_IRQ-1:0]    s1_q;
   logic [NUM_IRQ-1:0]    s2_q;
   logic [NUM_IRQ-1:0]    s3_q;
   // activation offer
   logic                  out_v_q;
   logic                  out_v_d;
   logic [IDX_W-1:0]      out_n_q;
   logic [IDX_W-1:0]      out_n_d;
   logic                  take;
   // arbiter result
   logic [PW-1:0]         win_prio;
   logic [IDX_W-1:0]      win_idx;
   logic                  found;
   // register access from the bus front end
   iec_pkg::iec_acc_s     acc;
   logic                  acc_go;
   logic                  acc_err;
   logic [31:0]           acc_rdata;

   // byte-lane mask from write strobes
   function automatic logic [31:0] lane_mask(input logic [3:0] s);
      lane_mask = {{LW{s[3]}}, {LW{s[2]}}, {LW{s[1]}}, {LW{s[0]}}};
   endfunction

   // bank word index of an address within a bank, or -1 when outside
   function automatic int bank_word(input logic [11:0] a,
                                    input logic [11:0] base);
      if (a >= base && a < base + iec_pkg::BANK_SPAN &&
          (int'(a - base) >> iec_pkg::WORD_SH) < NW)
         bank_word = int'(a - base) >> iec_pkg::WORD_SH;
      else
         bank_word = -1;
   endfunction

   // visibility of a word: bits whose target state admits the accessor
   function automatic logic [31:0] vis(input logic [NUM_IRQ-1:0] t,
                                       input int w, input logic ns,
                                       input logic ext);
      vis = (ext && ns) ? t[w*BB +: BB] : 32'hffff_ffff; // (R9) (R10)
   endfunction

   iec_axil_slave u_bus (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .ce        (ce),
      .s_awaddr  (s_awaddr),
      .s_awprot  (s_awprot),
      .s_awvalid (s_awvalid),
      .s_awready (s_awready),
      .s_wdata   (s_wdata),
      .s_wstrb   (s_wstrb),
      .s_wvalid  (s_wvalid),
      .s_wready  (s_wready),
      .s_bresp   (s_bresp),
      .s_bvalid  (s_bvalid),
      .s_bready  (s_bready),
      .s_araddr  (s_araddr),
      .s_arprot  (s_arprot),
      .s_arvalid (s_arvalid),
      .s_arready (s_arready),
      .s_rdata   (s_rdata),
      .s_rresp   (s_rresp),
      .s_rvalid  (s_rvalid),
      .s_rready  (s_rready),
      .acc       (acc),
      .acc_go    (acc_go),
      .acc_rdata (acc_rdata),
      .acc_err   (acc_err)
   );

   // candidates are pending and enabled only (R6) (R8)
   iec_arbiter #(
      .NUM_IRQ (NUM_IRQ),
      .PRIO_W  (PW),
      .IDX_W   (IDX_W)
   ) u_arb (
      .cand     (pend_q & en_q),
      .prio     (pri_q),
      .found    (found),
      .win_idx  (win_idx),
      .win_prio (win_prio)
   );

   // outputs straight from registers
   assign enabled    = en_q;
   assign act_valid  = out_v_q;
   assign act_number = out_n_q;

   // a take is the one cycle with offer and ready both high
   assign take = out_v_q && act_ready;

   // register decode, read mux and state updates
   always_comb begin
      int          w;
      int          pw;
      int          fi;
      logic [31:0] m;
      logic [31:0] v;
      w = 0;
      pw = 0;
      fi = 0;
      m = '0;
      v = '0;
      en_d = en_q;
      pend_d = pend_q;
      tgt_d = tgt_q;
      pri_d = pri_q;
      secext_d = secext_q;
      acc_rdata = '0;
      acc_err = 1'b0;
      // activation taken by the core leaves pending
      if (take)
         pend_d[out_n_q] = 1'b0;
      // synced rising edge pends, enabled or not; beats a same-cycle take
      pend_d = pend_d | (s2_q & ~s3_q); // (R7)
      // byte lanes of a write
      m = lane_mask(acc.strb);
      if (acc_go) begin
         if (bank_word(acc.addr, iec_pkg::OFS_SET_BASE) >= 0) begin
            // set bank: write one enables, read shows enable state
            w = bank_word(acc.addr, iec_pkg::OFS_SET_BASE); // (R1)
            v = vis(tgt_q, w, acc.nonsec, secext_q);
            acc_rdata = en_q[w*BB +: BB] & v; // (R5) (R2)
            if (acc.wr)
               en_d[w*BB +: BB] = en_q[w*BB +: BB] |
                                  (acc.data & m & v); // (R3)
         end else if (bank_word(acc.addr, iec_pkg::OFS_CLR_BASE) >= 0) begin
            // clear bank: write one disables, read shows enable state
            w = bank_word(acc.addr, iec_pkg::OFS_CLR_BASE); // (R1)
            v = vis(tgt_q, w, acc.nonsec, secext_q);
            acc_rdata = en_q[w*BB +: BB] & v; // (R5)
            if (acc.wr)
               en_d[w*BB +: BB] = en_q[w*BB +: BB] &
                                  ~(acc.data & m & v); // (R4)
         end else if (bank_word(acc.addr, iec_pkg::OFS_PEND_BASE) >= 0) begin
            // pending bank: write one pends, after any take clear
            w = bank_word(acc.addr, iec_pkg::OFS_PEND_BASE);
            v = vis(tgt_q, w, acc.nonsec, secext_q);
            acc_rdata = pend_q[w*BB +: BB] & v;
            if (acc.wr)
               pend_d[w*BB +: BB] = pend_d[w*BB +: BB] | (acc.data & m & v);
         end else if (bank_word(acc.addr, iec_pkg::OFS_TGT_BASE) >= 0) begin
            // target bank: secure access only, and only with the extension
            w = bank_word(acc.addr, iec_pkg::OFS_TGT_BASE);
            if (!(acc.nonsec && secext_q) && secext_q) begin // (R12)
               acc_rdata = tgt_q[w*BB +: BB];
               if (acc.wr)
                  tgt_d[w*BB +: BB] = (tgt_q[w*BB +: BB] & ~m) | (acc.data & m);
            end
         end else if (acc.addr >= iec_pkg::OFS_PRIO_BASE &&
                      acc.addr < iec_pkg::OFS_PRIO_BASE + 12'(NUM_IRQ)) begin
            pw = int'(acc.addr - iec_pkg::OFS_PRIO_BASE) >> iec_pkg::WORD_SH;
            // four 8-bit fields per word, one per byte lane
            for (int b = 0; b < LN; b++) begin
               fi = pw * LN + b;
               if (!(secext_q && acc.nonsec && !tgt_q[fi])) begin
                  acc_rdata[b*LW +: LW] = pri_q[fi*PW +: PW];
                  if (acc.wr && acc.strb[b])
                     pri_d[fi*PW +: PW] = acc.data[b*LW +: LW];
               end
            end
         end else if (acc.addr == iec_pkg::OFS_CTRL) begin
            acc_rdata[iec_pkg::CTRL_SECEXT_BIT] = secext_q;
            // only a secure access may change the security extension
            if (acc.wr && !acc.nonsec && acc.strb[0])
               secext_d = acc.data[iec_pkg::CTRL_SECEXT_BIT];
         end else if (acc.addr == iec_pkg::OFS_RESULT) begin
            // result word: found, winner number and its level
            acc_rdata[iec_pkg::RES_VALID_BIT] = found;
            acc_rdata[IDX_W-1:0] = win_idx;
            acc_rdata[iec_pkg::RES_PRIO_LSB +: PW] = win_prio;
         end else begin
            acc_err = 1'b1; // unmapped: slverr, reads zero
         end
      end
   end

   // activation offer: the arbiter sees the new enable next cycle (R14)
   always_comb begin
      out_v_d = out_v_q;
      out_n_d = out_n_q;
      if (!out_v_q || act_ready) begin
         // never offer one that was just taken and not pended again
         out_v_d = found && pend_d[win_idx] && en_d[win_idx]; // (R8) (R13)
         out_n_d = win_idx;
      end else if (!en_d[out_n_q]) begin
         // a stalled offer goes away with its enable, so it is never taken
         out_v_d = 1'b0; // (R8)
      end
   end

   // enable, pending, target, priority and control state
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         en_q <= '0;
         pend_q <= '0;
         tgt_q <= '0;
         pri_q <= '0;
         secext_q <= 1'b0;
      end else if (ce) begin
         en_q <= en_d;
         pend_q <= pend_d;
         tgt_q <= tgt_d;
         pri_q <= pri_d;
         secext_q <= secext_d;
      end
   end

   // two flops against metastability, a third only for edge detect
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
      end else if (ce) begin
         s1_q <= irq_lines; // first stage read only by s2
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // activation offer registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         out_v_q <= 1'b0;
         out_n_q <= '0;
      end else if (ce) begin
         out_v_q <= out_v_d;
         out_n_q <= out_n_d;
      end
   end
endmodule
`default_nettype wire

/* File: core/iec_pkg.sv */
// package: register map, field layout and carrier types for the enable block
package iec_pkg;

   // bus widths
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;

   // word-aligned byte offsets of the register banks
   localparam logic [11:0] OFS_SET_BASE   = 12'h100;
   localparam logic [11:0] OFS_CLR_BASE   = 12'h180;
   localparam logic [11:0] OFS_PEND_BASE  = 12'h200;
   localparam logic [11:0] OFS_TGT_BASE   = 12'h380;
   localparam logic [11:0] OFS_PRIO_BASE  = 12'h400;
   localparam logic [11:0] OFS_CTRL       = 12'h800;
   localparam logic [11:0] OFS_RESULT     = 12'h804;
   localparam logic [11:0] BANK_SPAN      = 12'h040;

   // field layout of the control and result words, and bank, lane and priority widths
   localparam int CTRL_SECEXT_BIT = 0;
   localparam int RES_VALID_BIT   = 31;
   localparam int PRIO_W          = 8;
   localparam int BANK_BITS       = 32;
   localparam int LANE_W          = 8;
   localparam int LANES           = 4;
   localparam int WORD_SH         = 2;
   localparam int RES_PRIO_LSB    = 8;

   // reset values
   localparam logic [31:0] RST_WORD = 32'h0000_0000;

   // axi response codes
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // one decoded register access
   typedef struct packed {
      logic              wr;
      logic [11:0]       addr;
      logic [31:0]       data;
      logic [3:0]        strb;
      logic              nonsec;
   } iec_acc_s;
endpackage

/* File: core/iec_axil_slave.sv */
// axi4-lite slave front end: collects requests, returns answers
`timescale 1ns/1ps
`default_nettype none
module iec_axil_slave (
   // clock and reset
   input  wire logic                 aclk,
   input  wire logic                 aresetn,
   input  wire logic                 ce,
   // axi4-lite
   input  wire logic [11:0]          s_awaddr,
   input  wire logic [2:0]           s_awprot,
   input  wire logic                 s_awvalid,
   output logic                      s_awready,
   input  wire logic [31:0]          s_wdata,
   input  wire logic [3:0]           s_wstrb,
   input  wire logic                 s_wvalid,
   output logic                      s_wready,
   output logic [1:0]                s_bresp,
   output logic                      s_bvalid,
   input  wire logic                 s_bready,
   input  wire logic [11:0]          s_araddr,
   input  wire logic [2:0]           s_arprot,
   input  wire logic                 s_arvalid,
   output logic                      s_arready,
   output logic [31:0]               s_rdata,
   output logic [1:0]                s_rresp,
   output logic                      s_rvalid,
   input  wire logic                 s_rready,
   // register side
   output iec_pkg::iec_acc_s         acc,
   output logic                      acc_go,
   input  wire logic [31:0]          acc_rdata,
   input  wire logic                 acc_err
);
   logic aw_q, aw_d, w_q, w_d, b_q, b_d, r_q, r_d;
   logic [11:0] awa_q, awa_d;
   logic        awns_q, awns_d;
   logic [31:0] wd_q, wd_d, rd_q, rd_d;
   logic [3:0]  ws_q, ws_d;
   logic [1:0]  br_q, br_d, rr_q, rr_d;
   logic        do_wr, do_rd;

   // channels are taken while their holding slot is empty; write channels also wait until no write answer is held
   assign s_awready = ce && !aw_q && !b_q;
   assign s_wready  = ce && !w_q && !b_q;
   assign s_arready = ce && !r_q && !do_wr;
   assign s_bvalid  = b_q;
   assign s_bresp   = br_q;
   assign s_rvalid  = r_q;
   assign s_rresp   = rr_q;
   assign s_rdata   = rd_q;
   assign do_wr     = ce && aw_q && w_q && !b_q;
   // write wins the register port; reads wait a cycle
   assign do_rd     = s_arvalid && s_arready;
   assign acc_go    = do_wr || do_rd;

   // next-state for slots and access mux
   always_comb begin
      aw_d = aw_q; w_d = w_q; b_d = b_q; r_d = r_q;
      awa_d = awa_q; awns_d = awns_q; wd_d = wd_q; ws_d = ws_q;
      br_d = br_q; rr_d = rr_q; rd_d = rd_q;
      if (s_awvalid && s_awready) begin
         aw_d = 1'b1; awa_d = s_awaddr; awns_d = s_awprot[1];
      end
      if (s_wvalid && s_wready) begin
         w_d = 1'b1; wd_d = s_wdata; ws_d = s_wstrb;
      end
      if (s_bvalid && s_bready) b_d = 1'b0;
      if (s_rvalid && s_rready) r_d = 1'b0;
      acc = '0;
      if (do_wr) begin
         acc.wr = 1'b1; acc.addr = awa_q; acc.data = wd_q;
         acc.strb = ws_q; acc.nonsec = awns_q;
         aw_d = 1'b0; w_d = 1'b0; b_d = 1'b1;
         br_d = acc_err ? iec_pkg::RESP_SLVERR : iec_pkg::RESP_OKAY;
      end else if (do_rd) begin
         acc.addr = s_araddr; acc.nonsec = s_arprot[1];
         r_d = 1'b1; rd_d = acc_rdata;
         rr_d = acc_err ? iec_pkg::RESP_SLVERR : iec_pkg::RESP_OKAY;
      end
   end

   // registers only
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_q <= 1'b0; w_q <= 1'b0; b_q <= 1'b0; r_q <= 1'b0;
         awa_q <= '0; awns_q <= 1'b0; wd_q <= '0; ws_q <= '0;
         br_q <= '0; rr_q <= '0; rd_q <= '0;
      end else if (ce) begin
         aw_q <= aw_d; w_q <= w_d; b_q <= b_d; r_q <= r_d;
         awa_q <= awa_d; awns_q <= awns_d; wd_q <= wd_d; ws_q <= ws_d;
         br_q <= br_d; rr_q <= rr_d; rd_q <= rd_d;
      end
   end
endmodule
`default_nettype wire

/* File: core/iec_arbiter.sv */
// combinational pick of the most urgent enabled pending interrupt
`timescale 1ns/1ps
`default_nettype none
module iec_arbiter #(
   parameter int NUM_IRQ = 64,
   parameter int PRIO_W  = 8,
   parameter int IDX_W   = 6
) (
   // candidates
   input  wire logic [NUM_IRQ-1:0]        cand,
   input  wire logic [NUM_IRQ*PRIO_W-1:0] prio,
   // winner
   output logic                           found,
   output logic [IDX_W-1:0]               win_idx,
   output logic [PRIO_W-1:0]              win_prio
);
   // lower value is more urgent, zero the most urgent (R13)
   // linear scan; ties go to the lower number, strict less-than keeps it
   always_comb begin
      found    = 1'b0;
      win_idx  = '0;
      win_prio = '1;
      for (int i = 0; i < NUM_IRQ; i++) begin
         if (cand[i] && (!found || prio[i*PRIO_W +: PRIO_W] < win_prio)) begin
            found    = 1'b1;
            win_idx  = IDX_W'(i);
            win_prio = prio[i*PRIO_W +: PRIO_W];
         end
      end
   end
endmodule
`default_nettype wire

/* File: bench/iec_enable_ctrl_properties.sv */
// checker: bus answer timing and enable-to-activation relations
`timescale 1ns/1ps
`default_nettype none
module iec_enable_ctrl_properties #(
   parameter int NUM_IRQ = 64,
   parameter int IDX_W   = 6
) (
   // clock and reset
   input wire logic               aclk,
   input wire logic               aresetn,
   input wire logic               ce,
   // activation and state
   input wire logic               act_valid,
   input wire logic [IDX_W-1:0]   act_number,
   input wire logic [NUM_IRQ-1:0] enabled,
   // write channels
   input wire logic               s_awvalid,
   input wire logic               s_awready,
   input wire logic               s_wvalid,
   input wire logic               s_wready,
   input wire logic               s_bvalid,
   input wire logic               s_bready,
   input wire logic [1:0]         s_bresp,
   // read channels
   input wire logic               s_arvalid,
   input wire logic               s_arready,
   input wire logic               s_rvalid,
   input wire logic               s_rready,
   input wire logic [31:0]        s_rdata
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // request acceptance on each side
   sequence wr_take;
      ce && s_awvalid && s_awready && s_wvalid && s_wready;
   endsequence
   sequence rd_take;
      ce && s_arvalid && s_arready;
   endsequence

   enable_change_a: assert property (
      $changed(enabled) |-> s_bvalid || $past(s_bvalid))
      else $error("enable state moved without a write");
   act_enabled_a: assert property (
      act_valid |-> enabled[act_number])
      else $error("offer made for a disabled interrupt");
   wr_answer_a: assert property (wr_take |-> ##2 s_bvalid)
      else $error("write answer late");
   rd_answer_a: assert property (rd_take |=> s_rvalid)
      else $error("read answer late");
   bvalid_hold_a: assert property (
      s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp))
      else $error("write answer dropped early");
   rvalid_hold_a: assert property (
      s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
      else $error("read answer dropped early");
   wr_busy_a: assert property (
      s_bvalid |-> !(s_awvalid && s_awready))
      else $error("write taken while answer pending");
   rd_busy_a: assert property (
      s_rvalid |-> !(s_arvalid && s_arready))
      else $error("read taken while answer pending");
endmodule

bind iec_enable_ctrl iec_enable_ctrl_properties #(
   .NUM_IRQ(NUM_IRQ), .IDX_W(IDX_W)) props_i (.*);
`default_nettype wire

/* File: bench/iec_core_model.sv */
// core-side model: takes activation offers promptly or slowly
`timescale 1ns/1ps
`default_nettype none
module iec_core_model (
   // clock and reset
   input  wire logic       aclk,
   input  wire logic       aresetn,
   // offer from the block
   input  wire logic       act_valid,
   input  wire logic [5:0] act_number,
   output logic            act_ready,
   // pace control and take log
   input  wire logic       slow,
   output logic [23:0]     hist_q
);
   logic [1:0]  wait_q;
   logic [1:0]  wait_d;
   logic [23:0] hist_d;

   // slow mode stalls each offer three cycles before taking it
   always_comb begin
      act_ready = act_valid && (!slow || wait_q == 2'h3);
      wait_d = (act_valid && !act_ready) ? wait_q + 2'h1 : 2'h0;
      hist_d = act_ready ? {hist_q[17:0], act_number} : hist_q;
   end

   // log of taken numbers, newest in the low bits
   always_ff @(posedge aclk) begin
      wait_q <= aresetn ? wait_d : 2'h0;
      hist_q <= aresetn ? hist_d : 24'h0;
   end
endmodule
`default_nettype wire

/* File: bench/iec_enable_ctrl_tb_top.sv */
// testbench: enable banks, security view and activation order
`timescale 1ns/1ps
`default_nettype none
module iec_enable_ctrl_tb_top;
   localparam logic [11:0] SET_A = iec_pkg::OFS_SET_BASE;
   localparam logic [11:0] CLR_A = iec_pkg::OFS_CLR_BASE;
   localparam logic [11:0] PND_A = iec_pkg::OFS_PEND_BASE;
   localparam logic [11:0] TGT_A = iec_pkg::OFS_TGT_BASE;
   localparam logic [11:0] PRI_A = iec_pkg::OFS_PRIO_BASE;
   logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, slow = 1'b0;
   logic [63:0] irq_lines = 64'h0;
   logic act_valid, act_ready;
   logic [5:0] act_number;
   logic [23:0] hist_q, h;
   logic [11:0] s_awaddr = 12'h0, s_araddr = 12'h0;
   logic [2:0] s_awprot = 3'h0, s_arprot = 3'h0;
   logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_arvalid = 1'b0;
   logic s_bready = 1'b0, s_rready = 1'b0;
   logic [31:0] s_wdata = 32'h0;
   logic [3:0] s_wstrb = 4'hf;
   logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
   logic [1:0] s_bresp, s_rresp;
   logic [31:0] s_rdata;
   logic [63:0] enabled;
   int bad_count = 0, check_count = 0, cyc = 0;

   iec_enable_ctrl #(.NUM_IRQ(64), .IDX_W(6)) dut (.*);
   iec_core_model core_i (.*);

   // 125 MHz clock and a hang guard
   always #4 aclk = ~aclk;
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         results();
      end
   end

   task automatic chk(input string nm, input logic [63:0] e, g);
      check_count++;
      if (g !== e) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   // write: bready offered with the request and left high between calls
   task automatic axw(input logic [11:0] a, input logic [31:0] d,
                      input logic ns, input logic [1:0] er);
      s_awaddr <= a;
      s_awprot <= {1'b0, ns, 1'b0};
      s_wdata <= d;
      s_awvalid <= 1'b1;
      s_wvalid <= 1'b1;
      s_bready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (s_awvalid && s_awready) s_awvalid <= 1'b0;
         if (s_wvalid && s_wready) s_wvalid <= 1'b0;
         if (s_bvalid && s_bready) break;
      end
      chk("bresp", 64'(er), 64'(s_bresp));
   endtask

   task automatic axr(input logic [11:0] a, input logic ns,
                      input logic [1:0] er, input logic [31:0] ed);
      s_araddr <= a;
      s_arprot <= {1'b0, ns, 1'b0};
      s_arvalid <= 1'b1;
      s_rready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (s_arvalid && s_arready) s_arvalid <= 1'b0;
         if (s_rvalid && s_rready) break;
      end
      chk("rresp", 64'(er), 64'(s_rresp));
      chk("rdata", 64'(ed), 64'(s_rdata));
   endtask

   task automatic wait_take(input logic [23:0] old);
      int n;
      n = 0;
      while (hist_q === old && n < 50) begin
         @(posedge aclk);
         n++;
      end
      chk("take", 64'h1, 64'(hist_q !== old));
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // main sequence
   initial begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      for (int n = 0; n < 2; n++) begin
         axr(SET_A + 12'(4 * n), 1'b0, 2'h0, 32'h0);
         axr(CLR_A + 12'(4 * n), 1'b0, 2'h0, 32'h0);
      end
      axw(SET_A, 32'h8000_0001, 1'b0, 2'h0);
      axw(SET_A + 12'h4, 32'h0000_0004, 1'b0, 2'h0);
      chk("enabled", 64'h0000_0004_8000_0001, enabled);
      axr(CLR_A, 1'b0, 2'h0, 32'h8000_0001);
      axr(CLR_A + 12'h4, 1'b0, 2'h0, 32'h0000_0004);
      axw(SET_A, 32'h0, 1'b0, 2'h0);
      axw(CLR_A, 32'h0, 1'b0, 2'h0);
      axw(CLR_A, 32'h0000_0001, 1'b0, 2'h0);
      chk("enabled", 64'h0000_0004_8000_0000, enabled);
      axr(12'h7f0, 1'b0, iec_pkg::RESP_SLVERR, 32'h0);
      // disabled line pends but is never offered
      irq_lines[5] <= 1'b1;
      repeat (20) @(posedge aclk);
      chk("act_valid", 64'h0, 64'(act_valid));
      axr(PND_A, 1'b0, 2'h0, 32'h0000_0020);
      h = hist_q;
      axw(SET_A, 32'h0000_0020, 1'b0, 2'h0);
      wait_take(h);
      chk("taken", 64'h5, 64'(hist_q[5:0]));
      irq_lines[5] <= 1'b0;
      // two candidates enabled at once, slow core: urgency order
      slow <= 1'b1;
      axw(PRI_A, 32'h4000_0000, 1'b0, 2'h0);
      axw(PRI_A + 12'h4, 32'h1000_0000, 1'b0, 2'h0);
      axw(PND_A, 32'h0000_0088, 1'b0, 2'h0);
      h = hist_q;
      axw(SET_A, 32'h0000_0088, 1'b0, 2'h0);
      wait_take(h);
      h = hist_q;
      wait_take(h);
      chk("order", 64'({6'h07, 6'h03}), 64'(hist_q[11:0]));
      // a stalled offer whose enable is cleared is withdrawn, not taken
      axw(PND_A, 32'h0000_0200, 1'b0, 2'h0);
      h = hist_q;
      axw(SET_A, 32'h0000_0200, 1'b0, 2'h0);
      axw(CLR_A, 32'h0000_0200, 1'b0, 2'h0);
      repeat (8) @(posedge aclk);
      chk("withdrawn", 64'(h), 64'(hist_q));
      chk("act_valid", 64'h0, 64'(act_valid));
      // security view: extension off, then on
      axw(TGT_A, 32'h0000_00f0, 1'b0, 2'h0);
      axr(TGT_A, 1'b0, 2'h0, 32'h0);
      axw(iec_pkg::OFS_CTRL, 32'h0000_0001, 1'b0, 2'h0);
      axw(TGT_A, 32'h0000_00f0, 1'b0, 2'h0);
      axw(TGT_A, 32'hffff_ffff, 1'b1, 2'h0);
      axr(TGT_A, 1'b1, 2'h0, 32'h0);
      axr(TGT_A, 1'b0, 2'h0, 32'h0000_00f0);
      axr(SET_A, 1'b1, 2'h0, 32'h0000_00a0);
      axr(SET_A + 12'h4, 1'b1, 2'h0, 32'h0);
      axr(CLR_A, 1'b1, 2'h0, 32'h0000_00a0);
      axw(SET_A, 32'h0000_0311, 1'b1, 2'h0);
      axw(CLR_A, 32'h8000_0020, 1'b1, 2'h0);
      axr(SET_A, 1'b0, 2'h0, 32'h8000_0098);
      axr(CLR_A, 1'b0, 2'h0, 32'h8000_0098);
      results();
   end
endmodule
`default_nettype wire
